/* File: asd_pkg.sv */
package asd_pkg;

    // register port geometry
    localparam int unsigned ASD_ADDR_W = 8;
    localparam int unsigned ASD_DATA_W = 16;
    localparam int unsigned ASD_NREG   = 5;

    // register offsets
    localparam logic [7:0] ASD_OFS_WINDOW  = 8'h3f;
    localparam logic [7:0] ASD_OFS_PATH    = 8'h42;
    localparam logic [7:0] ASD_OFS_CHGAIN  = 8'h55;
    localparam logic [7:0] ASD_OFS_DI_EN   = 8'h58;
    localparam logic [7:0] ASD_OFS_DI_OPT  = 8'h5a;

    // register indices inside the bank
    localparam int unsigned ASD_IDX_WINDOW = 0;
    localparam int unsigned ASD_IDX_PATH   = 1;
    localparam int unsigned ASD_IDX_CHGAIN = 2;
    localparam int unsigned ASD_IDX_DI_EN  = 3;
    localparam int unsigned ASD_IDX_DI_OPT = 4;

    localparam logic [7:0] ASD_REG_OFS [ASD_NREG] = '{
        ASD_OFS_WINDOW, ASD_OFS_PATH, ASD_OFS_CHGAIN, ASD_OFS_DI_EN, ASD_OFS_DI_OPT};

    // values after reset
    localparam logic [15:0] ASD_RST_WINDOW = 16'h22fc;
    localparam logic [15:0] ASD_RST_PATH   = 16'h1c38;
    localparam logic [15:0] ASD_RST_CHGAIN = 16'h0000;
    localparam logic [15:0] ASD_RST_DI_EN  = 16'h0000;
    localparam logic [15:0] ASD_RST_DI_OPT = 16'h0000;

    localparam logic [15:0] ASD_REG_RST [ASD_NREG] = '{
        ASD_RST_WINDOW, ASD_RST_PATH, ASD_RST_CHGAIN, ASD_RST_DI_EN, ASD_RST_DI_OPT};

    // field positions: digital integration enable
    localparam int unsigned ASD_POS_B_DI_EN   = 13;
    localparam int unsigned ASD_POS_A_DI_EN   = 12;
    // field positions: digital integration options
    localparam int unsigned ASD_POS_GAP_EN    = 7;
    localparam int unsigned ASD_POS_B_SINGLE  = 6;
    localparam int unsigned ASD_POS_A_SINGLE  = 5;
    // field positions: slot a window
    localparam int unsigned ASD_POS_WIDTH_LO  = 11;
    localparam int unsigned ASD_POS_COARSE_LO = 5;
    localparam int unsigned ASD_POS_FINE_LO   = 0;
    // field positions: slot a path mode and gain
    localparam int unsigned ASD_POS_MODE_LO   = 8;
    localparam int unsigned ASD_POS_IND_EN    = 6;
    localparam int unsigned ASD_POS_GAIN_LO   = 0;
    // field positions: per channel gain and power
    localparam int unsigned ASD_POS_CH2_LO    = 0;
    localparam int unsigned ASD_POS_CH3_LO    = 2;
    localparam int unsigned ASD_POS_CH4_LO    = 4;
    localparam int unsigned ASD_POS_PWR_LO    = 13;

    // path mode codes
    localparam logic [7:0] ASD_MODE_NORMAL = 8'h1c;
    localparam logic [7:0] ASD_MODE_DIGINT = 8'h1d;

    // power field codes
    localparam logic [2:0] ASD_PWR_ALL_ON  = 3'h0;
    localparam logic [2:0] ASD_PWR_DOWN    = 3'h7;

    // transimpedance gain codes
    typedef enum logic [1:0] {
        ASD_GAIN_200K = 2'h0,
        ASD_GAIN_100K = 2'h1,
        ASD_GAIN_50K  = 2'h2,
        ASD_GAIN_25K  = 2'h3
    } asd_gain_t;

endpackage

/* File: asd_reg_cell.sv */
`timescale 1ns/10ps
module asd_reg_cell
    import asd_pkg::*;
#(
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // write side
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    // stored word
    output logic      [15:0] q
);

    logic [15:0] word_q;

    // one sixteen bit storage word
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            word_q <= RESET_VAL;
        end else if (wr_en) begin
            word_q <= wr_data;
        end
    end

    assign q = word_q;

endmodule // asd_reg_cell

/* File: asd_cfg_regs.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - bit 13 of the enable register puts slot b into digital integration
// - bit 12 of the enable register puts slot a into digital integration
// - gap mode off: negative and positive sample regions abut without gap
// - gap mode on: gap equals that slot's own fine offset in microseconds
// - options bit 6: slot b double pair when clear, single pair when set
// - options bit 5: slot a double pair when clear, single pair when set
// - window bits 15:11 give slot a width in microseconds, reset 4
// - window bits 10:5 give slot a coarse offset in microseconds, reset 0x17
// - window bits 4:0 give slot a fine offset in 31.25 ns, reset 0x1c
// - path mode 0x1c means full normal chain, 0x1d means digital integration
// - bit 6 enables per channel gain: channel 1 shared, 2 to 4 from 0x55
// - gain codes 0..3 are 200k,100k,50k,25k; shared unless individual gain on
// - digital integration: power field 7 powers down channels 2 to 4
module asd_cfg_regs
    import asd_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr_en,
    input  wire logic [15:0] reg_wr_data,
    input  wire logic        reg_rd_en,
    output logic      [15:0] reg_rd_data_q,
    output logic             reg_rd_ack_q,
    // from slot b timing
    input  wire logic [4:0]  slot_b_window_fine_offset,
    // digital integration controls
    output logic             slot_a_digint_enable_q,
    output logic             slot_b_digint_enable_q,
    output logic             digint_gap_enable_q,
    output logic [4:0]       slot_a_gap_us_q,
    output logic [4:0]       slot_b_gap_us_q,
    output logic             slot_a_single_pair_select_q,
    output logic             slot_b_single_pair_select_q,
    // slot a window timing
    output logic [4:0]       slot_a_window_width_q,
    output logic [5:0]       slot_a_window_coarse_offset_q,
    output logic [4:0]       slot_a_window_fine_offset_q,
    // slot a path and gain
    output logic [7:0]       slot_a_path_mode_q,
    output logic             slot_a_path_normal_q,
    output logic             slot_a_path_digint_q,
    output logic [1:0]       slot_a_ch1_gain_q,
    output logic [1:0]       slot_a_ch2_gain_q,
    output logic [1:0]       slot_a_ch3_gain_q,
    output logic [1:0]       slot_a_ch4_gain_q,
    output logic             ch234_power_down_q
);

    ////////////////////////////////////////////////////////////////////////////
    // register bank

    logic [15:0] reg_q   [ASD_NREG];
    logic [ASD_NREG-1:0] hit;

    // decode and storage, one cell per register
    genvar gi;
    generate
        for (gi = 0; gi < ASD_NREG; gi++) begin : g_reg
            assign hit[gi] = (reg_addr == ASD_REG_OFS[gi]);
            asd_reg_cell #(
                .RESET_VAL (ASD_REG_RST[gi])
            ) u_cell (
                .core_clk (core_clk),
                .reset_n  (reset_n),
                .wr_en    (reg_wr_en && hit[gi]),
                .wr_data  (reg_wr_data),
                .q        (reg_q[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read path

    logic [15:0] rd_mux;
    wire         rd_hit = |hit;

    // or-mux of the selected word, unmapped reads give zero
    always_comb begin
        rd_mux = 16'h0000;
        for (int i = 0; i < ASD_NREG; i++) begin
            if (hit[i]) begin
                rd_mux = rd_mux | reg_q[i];
            end
        end
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rd_data_q <= 16'h0000;
            reg_rd_ack_q  <= 1'b0;
        end else begin
            reg_rd_ack_q <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rd_data_q <= rd_hit ? rd_mux : 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field extraction

    wire [15:0] win_w  = reg_q[ASD_IDX_WINDOW];
    wire [15:0] path_w = reg_q[ASD_IDX_PATH];
    wire [15:0] chg_w  = reg_q[ASD_IDX_CHGAIN];
    wire [15:0] den_w  = reg_q[ASD_IDX_DI_EN];
    wire [15:0] dop_w  = reg_q[ASD_IDX_DI_OPT];

    wire        a_en_d     = den_w[ASD_POS_A_DI_EN];
    wire        b_en_d     = den_w[ASD_POS_B_DI_EN];
    wire        gap_en_d   = dop_w[ASD_POS_GAP_EN];
    wire        a_single_d = dop_w[ASD_POS_A_SINGLE];
    wire        b_single_d = dop_w[ASD_POS_B_SINGLE];
    wire [4:0]  width_d    = win_w[ASD_POS_WIDTH_LO +: 5];
    wire [5:0]  coarse_d   = win_w[ASD_POS_COARSE_LO +: 6];
    wire [4:0]  fine_d     = win_w[ASD_POS_FINE_LO +: 5];
    wire [7:0]  mode_d     = path_w[ASD_POS_MODE_LO +: 8];
    wire        ind_en_d   = path_w[ASD_POS_IND_EN];
    wire [1:0]  shared_d   = path_w[ASD_POS_GAIN_LO +: 2];
    wire [2:0]  pwr_d      = chg_w[ASD_POS_PWR_LO +: 3];

    // gap: none when gap mode is off, else the slot's own fine offset
    wire [4:0]  a_gap_d = gap_en_d ? fine_d : 5'h00;
    wire [4:0]  b_gap_d = gap_en_d ? slot_b_window_fine_offset : 5'h00;

    // path mode decode
    wire        normal_d = (mode_d == ASD_MODE_NORMAL);
    wire        digint_d = (mode_d == ASD_MODE_DIGINT);

    // per channel gain select, channel 1 always shared
    wire [1:0]  ch2_d = ind_en_d ? chg_w[ASD_POS_CH2_LO +: 2] : shared_d;
    wire [1:0]  ch3_d = ind_en_d ? chg_w[ASD_POS_CH3_LO +: 2] : shared_d;
    wire [1:0]  ch4_d = ind_en_d ? chg_w[ASD_POS_CH4_LO +: 2] : shared_d;

    // channels 2 to 4 off only in digital integration with power code 7
    wire        pd_d = (a_en_d || b_en_d) && (pwr_d == ASD_PWR_DOWN);

    ////////////////////////////////////////////////////////////////////////////
    // output flops

    // digital integration controls
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            slot_a_digint_enable_q      <= 1'b0;
            slot_b_digint_enable_q      <= 1'b0;
            digint_gap_enable_q         <= 1'b0;
            slot_a_gap_us_q             <= 5'h00;
            slot_b_gap_us_q             <= 5'h00;
            slot_a_single_pair_select_q <= 1'b0;
            slot_b_single_pair_select_q <= 1'b0;
            ch234_power_down_q          <= 1'b0;
        end else begin
            slot_a_digint_enable_q      <= a_en_d;
            slot_b_digint_enable_q      <= b_en_d;
            digint_gap_enable_q         <= gap_en_d;
            slot_a_gap_us_q             <= a_gap_d;
            slot_b_gap_us_q             <= b_gap_d;
            slot_a_single_pair_select_q <= a_single_d;
            slot_b_single_pair_select_q <= b_single_d;
            ch234_power_down_q          <= pd_d;
        end
    end

    // slot a window and path
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            slot_a_window_width_q         <= ASD_RST_WINDOW[ASD_POS_WIDTH_LO +: 5];
            slot_a_window_coarse_offset_q <= ASD_RST_WINDOW[ASD_POS_COARSE_LO +: 6];
            slot_a_window_fine_offset_q   <= ASD_RST_WINDOW[ASD_POS_FINE_LO +: 5];
            slot_a_path_mode_q            <= ASD_RST_PATH[ASD_POS_MODE_LO +: 8];
            slot_a_path_normal_q          <= 1'b1;
            slot_a_path_digint_q          <= 1'b0;
        end else begin
            slot_a_window_width_q         <= width_d;
            slot_a_window_coarse_offset_q <= coarse_d;
            slot_a_window_fine_offset_q   <= fine_d;
            slot_a_path_mode_q            <= mode_d;
            slot_a_path_normal_q          <= normal_d;
            slot_a_path_digint_q          <= digint_d;
        end
    end

    // slot a channel gains
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            slot_a_ch1_gain_q <= ASD_GAIN_200K;
            slot_a_ch2_gain_q <= ASD_GAIN_200K;
            slot_a_ch3_gain_q <= ASD_GAIN_200K;
            slot_a_ch4_gain_q <= ASD_GAIN_200K;
        end else begin
            slot_a_ch1_gain_q <= shared_d;
            slot_a_ch2_gain_q <= ch2_d;
            slot_a_ch3_gain_q <= ch3_d;
            slot_a_ch4_gain_q <= ch4_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    wire wr_den = reg_wr_en && (reg_addr == ASD_OFS_DI_EN);
    wire wr_dop = reg_wr_en && (reg_addr == ASD_OFS_DI_OPT);
    wire wr_win = reg_wr_en && (reg_addr == ASD_OFS_WINDOW);
    wire wr_pth = reg_wr_en && (reg_addr == ASD_OFS_PATH);

    a_slot_b_enable: assert property (
        wr_den |-> ##2 (slot_b_digint_enable_q == $past(reg_wr_data[13], 2)))
        else $error("slot b digital integration enable does not follow write");

    a_slot_a_enable: assert property (
        wr_den |-> ##2 (slot_a_digint_enable_q == $past(reg_wr_data[12], 2)))
        else $error("slot a digital integration enable does not follow write");

    a_no_gap_off: assert property (
        !digint_gap_enable_q |-> (slot_a_gap_us_q == 5'h00 && slot_b_gap_us_q == 5'h00))
        else $error("gap present while gap mode is off");

    a_gap_fine_offset: assert property (
        digint_gap_enable_q |->
            (slot_a_gap_us_q == slot_a_window_fine_offset_q &&
             slot_b_gap_us_q == $past(slot_b_window_fine_offset)))
        else $error("gap differs from the slot fine offset");

    a_slot_b_pair: assert property (
        wr_dop |-> ##2 (slot_b_single_pair_select_q == $past(reg_wr_data[6], 2)))
        else $error("slot b sample pair select does not follow bit 6");

    a_slot_a_pair: assert property (
        wr_dop |-> ##2 (slot_a_single_pair_select_q == $past(reg_wr_data[5], 2)))
        else $error("slot a sample pair select does not follow bit 5");

    a_window_width: assert property (
        wr_win |-> ##2 (slot_a_window_width_q == $past(reg_wr_data[15:11], 2)))
        else $error("window width does not follow bits 15 to 11");

    a_window_coarse: assert property (
        wr_win |-> ##2 (slot_a_window_coarse_offset_q == $past(reg_wr_data[10:5], 2)))
        else $error("coarse offset does not follow bits 10 to 5");

    a_window_fine: assert property (
        wr_win |-> ##2 (slot_a_window_fine_offset_q == $past(reg_wr_data[4:0], 2)))
        else $error("fine offset does not follow bits 4 to 0");

    a_path_mode_codes: assert property (
        (slot_a_path_normal_q == (slot_a_path_mode_q == 8'h1c)) &&
        (slot_a_path_digint_q == (slot_a_path_mode_q == 8'h1d)))
        else $error("path mode flags disagree with the mode code");

    a_individual_gain: assert property (
        (wr_pth && reg_wr_data[6]) ##1 (!reg_wr_en)[*2] |->
            (slot_a_ch2_gain_q == $past(chg_w[1:0]) &&
             slot_a_ch3_gain_q == $past(chg_w[3:2]) &&
             slot_a_ch4_gain_q == $past(chg_w[5:4]) &&
             slot_a_ch1_gain_q == $past(path_w[1:0])))
        else $error("per channel gains not taken from their own fields");

    a_shared_gain: assert property (
        (wr_pth && !reg_wr_data[6]) ##1 (!reg_wr_en)[*2] |->
            (slot_a_ch1_gain_q == slot_a_ch2_gain_q &&
             slot_a_ch1_gain_q == slot_a_ch3_gain_q &&
             slot_a_ch3_gain_q == slot_a_ch4_gain_q &&
             slot_a_ch1_gain_q == $past(reg_wr_data[1:0], 2)))
        else $error("shared gain not applied to all four channels");

    a_power_down: assert property (
        ch234_power_down_q |->
            ($past(chg_w[15:13]) == 3'h7 && (slot_a_digint_enable_q || slot_b_digint_enable_q)))
        else $error("channels 2 to 4 powered down without cause");

    a_read_ack: assert property (
        reg_rd_en && !rd_hit |=> (reg_rd_ack_q && reg_rd_data_q == 16'h0000))
        else $error("unmapped read did not return zero");

    // every read strobe is answered on the next edge
    a_read_ack_next: assert property (
        reg_rd_en |=> reg_rd_ack_q)
        else $error("read strobe not acknowledged on the next edge");

    // read data stand until the next read strobe, no stray acknowledge
    a_rd_data_hold: assert property (
        !reg_rd_en |=> ($stable(reg_rd_data_q) && !reg_rd_ack_q))
        else $error("read data or acknowledge moved without a read");

    // a read of the options register returns the word held before the strobe edge
    a_rd_mapped: assert property (
        reg_rd_en && reg_addr == ASD_OFS_DI_OPT |=> reg_rd_data_q == $past(dop_w))
        else $error("read data differ from the options register");

    // power code 7 in digital integration must power channels down
    a_power_cause: assert property (
        ($past(chg_w[15:13]) == ASD_PWR_DOWN &&
         (slot_a_digint_enable_q || slot_b_digint_enable_q)) |-> ch234_power_down_q)
        else $error("channels 2 to 4 kept powered with power code 7");

    c_digint_a: cover property (wr_den && reg_wr_data[12] ##2 slot_a_digint_enable_q);
    c_gap_on: cover property (digint_gap_enable_q && slot_a_gap_us_q != 5'h00);
    c_ind_gain: cover property (wr_pth && reg_wr_data[6] ##3 slot_a_ch2_gain_q != slot_a_ch1_gain_q);
    c_powerdown: cover property ($rose(ch234_power_down_q));

endmodule // asd_cfg_regs

/* File: tb_top.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] %0t got %h expected %h", $time, (a), (b)); end end
module tb_top
    import asd_pkg::*;
;
    typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] r;} asd_tb_row_t;
    ////////////////////////////////////////////////////////////////////////////////
    // design hookup
    logic        core_clk, reset_n, reg_wr_en, reg_rd_en, reg_rd_ack_q;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wr_data, reg_rd_data_q;
    logic [4:0]  slot_b_window_fine_offset, slot_a_gap_us_q, slot_b_gap_us_q;
    logic        slot_a_digint_enable_q, slot_b_digint_enable_q, digint_gap_enable_q;
    logic        slot_a_single_pair_select_q, slot_b_single_pair_select_q;
    logic [4:0]  slot_a_window_width_q, slot_a_window_fine_offset_q;
    logic [5:0]  slot_a_window_coarse_offset_q;
    logic [7:0]  slot_a_path_mode_q;
    logic        slot_a_path_normal_q, slot_a_path_digint_q, ch234_power_down_q;
    logic [1:0]  slot_a_ch1_gain_q, slot_a_ch2_gain_q, slot_a_ch3_gain_q, slot_a_ch4_gain_q;
    int          miscompares, total_checks;
    logic [15:0] sh [ASD_NREG];
    asd_tb_row_t rows [20] = '{
        '{8'h58,16'h1000,16'h1000}, '{8'h58,16'h2000,16'h2000}, '{8'h5a,16'h0080,16'h0080},
        '{8'h5a,16'h0020,16'h0020}, '{8'h5a,16'h0040,16'h0040}, '{8'h5a,16'h00e0,16'h00e0},
        '{8'h3f,16'hffff,16'hffff}, '{8'h3f,16'h0000,16'h0000}, '{8'h3f,16'h0821,16'h0821},
        '{8'h42,16'h1d34,16'h1d34}, '{8'h55,16'he039,16'he039}, '{8'h42,16'h1c75,16'h1c75},
        '{8'h58,16'h3000,16'h3000}, '{8'h42,16'h1c36,16'h1c36}, '{8'h42,16'h1c37,16'h1c37},
        '{8'h55,16'h6000,16'h6000}, '{8'h42,16'h1c74,16'h1c74}, '{8'h43,16'hffff,16'h0000},
        '{8'h58,16'h0000,16'h0000}, '{8'h5a,16'h0000,16'h0000}};

    asd_cfg_regs dut (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
        .reg_rd_data_q(reg_rd_data_q), .reg_rd_ack_q(reg_rd_ack_q),
        .slot_b_window_fine_offset(slot_b_window_fine_offset),
        .slot_a_digint_enable_q(slot_a_digint_enable_q),
        .slot_b_digint_enable_q(slot_b_digint_enable_q),
        .digint_gap_enable_q(digint_gap_enable_q),
        .slot_a_gap_us_q(slot_a_gap_us_q), .slot_b_gap_us_q(slot_b_gap_us_q),
        .slot_a_single_pair_select_q(slot_a_single_pair_select_q),
        .slot_b_single_pair_select_q(slot_b_single_pair_select_q),
        .slot_a_window_width_q(slot_a_window_width_q),
        .slot_a_window_coarse_offset_q(slot_a_window_coarse_offset_q),
        .slot_a_window_fine_offset_q(slot_a_window_fine_offset_q),
        .slot_a_path_mode_q(slot_a_path_mode_q), .slot_a_path_normal_q(slot_a_path_normal_q),
        .slot_a_path_digint_q(slot_a_path_digint_q), .slot_a_ch1_gain_q(slot_a_ch1_gain_q),
        .slot_a_ch2_gain_q(slot_a_ch2_gain_q), .slot_a_ch3_gain_q(slot_a_ch3_gain_q),
        .slot_a_ch4_gain_q(slot_a_ch4_gain_q), .ch234_power_down_q(ch234_power_down_q));

    ////////////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    task give_verdict;
        if (miscompares == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // index of a mapped offset, or -1 when unmapped
    function automatic int idx_of(logic [7:0] a);
        for (int i = 0; i < ASD_NREG; i++) if (ASD_REG_OFS[i] == a) return i;
        return -1;
    endfunction

    // shadow copy tracks what the bank should hold
    task automatic shadow_wr(logic [7:0] a, logic [15:0] d);
        int k;
        k = idx_of(a);
        if (k >= 0) sh[k] = d;
    endtask

    // present a write at posedge+1; strobe left up for the caller to drop
    task automatic wr_start(logic [7:0] a, logic [15:0] d);
        reg_addr    = a;
        reg_wr_data = d;
        reg_wr_en   = 1'b1;
        shadow_wr(a, d);
        @(posedge core_clk);
        #1;
    endtask

    task automatic wr(logic [7:0] a, logic [15:0] d);
        wr_start(a, d);
        reg_wr_en = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    // read one word and compare against the expected word exp (0 when unmapped)
    task automatic rd(logic [7:0] a, logic [15:0] exp);
        int n;
        reg_addr  = a;
        reg_rd_en = 1'b1;
        @(posedge core_clk);
        #1;
        reg_rd_en = 1'b0;
        n = 0;
        while (reg_rd_ack_q !== 1'b1) begin
            if (n == 4) begin
                miscompares++;
                $display("[FAIL] %0t read acknowledge missing", $time);
                give_verdict();
            end
            n++;
            @(posedge core_clk);
            #1;
        end
        `CHK(n, 0);
        `CHK(reg_rd_data_q, exp);
        // let an edge pass: acknowledge drops, data stand
        @(posedge core_clk);
        #1;
        `CHK(reg_rd_ack_q, 1'b0);
        `CHK(reg_rd_data_q, exp);
    endtask

    // compare every decoded output against the shadow registers
    task automatic check_outs;
        logic [15:0] w, p, c, e, o;
        logic [1:0]  g1;
        w  = sh[ASD_IDX_WINDOW];
        p  = sh[ASD_IDX_PATH];
        c  = sh[ASD_IDX_CHGAIN];
        e  = sh[ASD_IDX_DI_EN];
        o  = sh[ASD_IDX_DI_OPT];
        g1 = p[1:0];
        `CHK(slot_b_digint_enable_q, e[13]);
        `CHK(slot_a_digint_enable_q, e[12]);
        `CHK(digint_gap_enable_q, o[7]);
        `CHK(slot_a_gap_us_q, o[7] ? w[4:0] : 5'h00);
        `CHK(slot_b_gap_us_q, o[7] ? slot_b_window_fine_offset : 5'h00);
        `CHK(slot_b_single_pair_select_q, o[6]);
        `CHK(slot_a_single_pair_select_q, o[5]);
        `CHK(slot_a_window_width_q, w[15:11]);
        `CHK(slot_a_window_coarse_offset_q, w[10:5]);
        `CHK(slot_a_window_fine_offset_q, w[4:0]);
        `CHK(slot_a_path_mode_q, p[15:8]);
        `CHK(slot_a_path_normal_q, p[15:8] == ASD_MODE_NORMAL);
        `CHK(slot_a_path_digint_q, p[15:8] == ASD_MODE_DIGINT);
        `CHK(slot_a_ch1_gain_q, g1);
        `CHK(slot_a_ch2_gain_q, p[6] ? c[1:0] : g1);
        `CHK(slot_a_ch3_gain_q, p[6] ? c[3:2] : g1);
        `CHK(slot_a_ch4_gain_q, p[6] ? c[5:4] : g1);
        `CHK(ch234_power_down_q, (e[12] | e[13]) && c[15:13] == ASD_PWR_DOWN);
    endtask

    // hold reset for 4 cycles, checking the reset state while it is held
    task automatic do_reset;
        reset_n = 1'b0;
        foreach (sh[i]) sh[i] = ASD_REG_RST[i];
        repeat (4) @(posedge core_clk);
        #1;
        check_outs();
        `CHK(reg_rd_ack_q, 1'b0);
        reset_n = 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        miscompares = 0;
        total_checks = 0;
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 16'h0000;
        reg_rd_en = 1'b0;
        slot_b_window_fine_offset = 5'h0b;
        do_reset();
        // reset values of every register
        for (int i = 0; i < ASD_NREG; i++) rd(ASD_REG_OFS[i], ASD_REG_RST[i]);
        // ordinary cases: write, check decoded outputs, read back
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            check_outs();
            rd(rows[i].a, rows[i].r);
        end
        // slot b gap follows its own fine offset input, one cycle late
        wr(ASD_OFS_DI_OPT, 16'h0080);
        wr(ASD_OFS_WINDOW, 16'h2213);
        slot_b_window_fine_offset = 5'h1e;
        repeat (2) @(posedge core_clk);
        #1;
        check_outs();
        `CHK(slot_a_gap_us_q, 5'h13);
        `CHK(slot_b_gap_us_q, 5'h1e);
        // back-to-back writes to two registers
        wr_start(ASD_OFS_DI_EN, 16'h1000);
        wr_start(ASD_OFS_CHGAIN, 16'he000);
        reg_wr_en = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check_outs();
        `CHK(ch234_power_down_q, 1'b1);
        // read and write together on one address: read sees the old word
        reg_rd_en = 1'b1;
        wr_start(ASD_OFS_PATH, 16'h1d35);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        `CHK(reg_rd_data_q, 16'h1c74);
        `CHK(reg_rd_ack_q, 1'b1);
        repeat (2) @(posedge core_clk);
        #1;
        check_outs();
        // reserved bits of the path register keep what software wrote
        wr(ASD_OFS_PATH, 16'h1c34);
        rd(ASD_OFS_PATH, 16'h1c34);
        // reset in mid-run brings every field back
        do_reset();
        check_outs();
        rd(ASD_OFS_WINDOW, ASD_RST_WINDOW);
        give_verdict();
    end
endmodule // tb_top
